// ---- design/sle_blink_div.v ----
// Shared blink divider producing a square phase and a toggle pulse
`timescale 1ns/1ps
`include "sle_map.vh"
module sle_blink_div #(
   parameter HALF_CYCLES = `SLE_BLINK_HALF_NS / `SLE_CLK_PERIOD_NS,
   parameter CW          = 25
) (
   // Clock and reset
   input  wire          sys_clk_i,
   input  wire          reset_n_i,
   // Blink outputs
   output reg           phase_o,
   output reg           tick_o
);

   reg [CW-1:0] cnt_q;

   // Count half period, flip phase at wrap
   always @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         cnt_q   <= {CW{1'b0}};
         phase_o <= 1'b0;
         tick_o  <= 1'b0;
      end
      else if (cnt_q == HALF_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1})
      begin
         cnt_q   <= {CW{1'b0}};
         phase_o <= ~phase_o;
         tick_o  <= 1'b1;
      end
      else
      begin
         cnt_q  <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
         tick_o <= 1'b0;
      end
   end

endmodule

// ---- design/sle_status_lamp_encoder.v ----
// Status lamp encoder: front lamps and six port link lamps
`timescale 1ns/1ps
`include "sle_map.vh"
module sle_status_lamp_encoder #(
   parameter NPORT       = 6,
   parameter BLINK_HALF  = `SLE_BLINK_HALF_NS / `SLE_CLK_PERIOD_NS,
   parameter BLINK_CW    = 25
) (
   // Clock and reset
   input  wire             sys_clk_i,
   input  wire             reset_n_i,
   // Supply and test conditions
   input  wire             supply_ok_i,
   input  wire             boot_i,
   input  wire             lamp_test_i,
   // Fault and firmware conditions
   input  wire             defect_i,
   input  wire             fw_fail_i,
   input  wire             fw_ok_i,
   // Operating and system state
   input  wire [2:0]       state_code_i,
   input  wire             init_done_i,
   input  wire             internal_act_i,
   input  wire             partner_paired_i,
   // Diagnostic conditions
   input  wire             diag_event_i,
   input  wire             maint_demand_i,
   input  wire             force_job_i,
   input  wire             fcycle_warn_i,
   input  wire             safety_off_i,
   input  wire             card_space_low_i,
   // Link port conditions
   input  wire [NPORT-1:0] link_up_i,
   input  wire [NPORT-1:0] link_act_i,
   // Front lamps
   output reg  [1:0]       run_stop_lamp_o,
   output reg              error_lamp_o,
   output reg              maintenance_lamp_o,
   // Link lamps, two bits per port: green high, yellow low
   output reg  [2*NPORT-1:0] link_lamp_o,
   // Status
   output reg              paired_run_o,
   output reg              card_write_abort_o
);

   // Pattern code and combinational lamp drive
   wire                 blink;
   reg  [3:0]           pat;
   reg  [1:0]           rs_d;
   reg                  er_d;
   reg                  mt_d;
   wire                 paired;
   wire [2*NPORT-1:0]   link_d;

   // One divider feeds every flashing lamp
   sle_blink_div #(
      .HALF_CYCLES (BLINK_HALF),
      .CW          (BLINK_CW)
   ) u_blink (
      .sys_clk_i   (sys_clk_i),
      .reset_n_i   (reset_n_i),
      .phase_o     (blink),
      .tick_o      ()
   );

   // Operating state decode, one flag per state code except run and run sync
   wire       st_stop     = (state_code_i == `SLE_ST_STOP);
   wire       st_startup  = (state_code_i == `SLE_ST_STARTUP);
   wire       st_warm     = (state_code_i == `SLE_ST_WARM);
   wire       st_run_pair = (state_code_i == `SLE_ST_RUN_PAIR);
   wire       st_syncup   = (state_code_i == `SLE_ST_SYNCUP);

   // Paired run counts only when both units agree; a lone unit
   // in paired run still keeps its maintenance lamp lit
   assign paired = st_run_pair && partner_paired_i;

   // Condition groups, one per pattern, in falling priority
   wire       c_dark     = ~supply_ok_i;
   wire       c_test     = boot_i | lamp_test_i;
   wire       c_defect   = defect_i | fw_fail_i;
   wire       c_fw_ok    = fw_ok_i;
   wire       c_warm     = st_warm;
   wire       c_syncup   = st_syncup;
   wire       c_internal = internal_act_i & ~paired;
   wire       c_stop     = st_stop | st_startup | init_done_i;
   wire       c_diag_mt  = diag_event_i & maint_demand_i;
   wire       c_diag     = diag_event_i & paired;
   wire       c_maint    = maint_demand_i;
   wire       c_flag     = force_job_i | fcycle_warn_i | safety_off_i;
   wire       c_run      = ~paired | c_flag;

   // Flash shapes, all cut from the one shared phase
   wire [1:0] fl_yg      = blink ? `SLE_LAMP_GREEN : `SLE_LAMP_YELLOW;
   wire [1:0] fl_y       = blink ? `SLE_LAMP_YELLOW : `SLE_LAMP_OFF;
   wire [1:0] fl_g       = blink ? `SLE_LAMP_GREEN : `SLE_LAMP_OFF;

   // Pattern selection by fixed priority
   // Unused state codes fall through to the run pattern, maintenance lit
   always @*
   begin
      pat = `SLE_PAT_CLEAN;
      if (c_dark)
         pat = `SLE_PAT_DARK;
      else if (c_test)
         pat = `SLE_PAT_TEST;
      else if (c_defect)
         pat = `SLE_PAT_DEFECT;
      else if (c_fw_ok)
         pat = `SLE_PAT_FW_OK;
      else if (c_warm)
         pat = `SLE_PAT_WARM;
      else if (c_syncup)
         pat = `SLE_PAT_SYNCUP;
      else if (c_internal)
         pat = `SLE_PAT_INTERNAL;
      else if (c_stop)
         pat = `SLE_PAT_STOP;
      else if (c_diag_mt)
         pat = `SLE_PAT_DIAG_MT;
      else if (c_diag)
         pat = `SLE_PAT_DIAG;
      else if (c_maint)
         pat = `SLE_PAT_MAINT;
      else if (c_run)
         pat = `SLE_PAT_RUN;
      else
         pat = `SLE_PAT_CLEAN;
   end

   // Pattern to lamp drive, every flash from the shared phase
   always @*
   begin
      rs_d = `SLE_LAMP_OFF;
      er_d = 1'b0;
      mt_d = 1'b0;
      case (pat)
         // Supply missing: everything dark
         `SLE_PAT_DARK:
         begin
            rs_d = `SLE_LAMP_OFF;
            er_d = 1'b0;
            mt_d = 1'b0;
         end

         // Boot, insertion or flash test: all three flash
         `SLE_PAT_TEST:
         begin
            rs_d = fl_yg;
            er_d = blink;
            mt_d = blink;
         end

         // Defect or failed update
         `SLE_PAT_DEFECT:
         begin
            rs_d = `SLE_LAMP_YELLOW;
            er_d = blink;
            mt_d = blink;
         end

         // Update done
         `SLE_PAT_FW_OK:
         begin
            rs_d = `SLE_LAMP_YELLOW;
            er_d = 1'b0;
            mt_d = blink;
         end

         // Stopped, starting or init complete
         `SLE_PAT_STOP:
         begin
            rs_d = `SLE_LAMP_YELLOW;
            er_d = 1'b0;
            mt_d = 1'b1;
         end

         // Primary startup, backup syncup
         `SLE_PAT_SYNCUP:
         begin
            rs_d = fl_yg;
            er_d = 1'b0;
            mt_d = 1'b1;
         end

         // Warm restart
         `SLE_PAT_WARM:
         begin
            rs_d = fl_y;
            er_d = 1'b0;
            mt_d = 1'b0;
         end

         // Internal activity outside paired run
         `SLE_PAT_INTERNAL:
         begin
            rs_d = fl_y;
            er_d = 1'b0;
            mt_d = 1'b1;
         end

         // Diagnostic event with maintenance demand
         `SLE_PAT_DIAG_MT:
         begin
            rs_d = `SLE_LAMP_GREEN;
            er_d = blink;
            mt_d = 1'b1;
         end

         // Diagnostic event in paired run
         `SLE_PAT_DIAG:
         begin
            rs_d = `SLE_LAMP_GREEN;
            er_d = blink;
            mt_d = 1'b0;
         end

         // Plant maintenance demanded
         `SLE_PAT_MAINT:
         begin
            rs_d = `SLE_LAMP_GREEN;
            er_d = 1'b0;
            mt_d = 1'b1;
         end

         // Run class or an active flag
         `SLE_PAT_RUN:
         begin
            rs_d = `SLE_LAMP_GREEN;
            er_d = 1'b0;
            mt_d = 1'b1;
         end

         // Clean paired run
         `SLE_PAT_CLEAN:
         begin
            rs_d = `SLE_LAMP_GREEN;
            er_d = 1'b0;
            mt_d = 1'b0;
         end

         // Unused pattern code: dark
         default:
         begin
            rs_d = `SLE_LAMP_OFF;
            er_d = 1'b0;
            mt_d = 1'b0;
         end
      endcase
   end

   // Register front lamps, one cycle behind the inputs
   always @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         run_stop_lamp_o    <= `SLE_LAMP_OFF;
         error_lamp_o       <= 1'b0;
         maintenance_lamp_o <= 1'b0;
      end
      else
      begin
         run_stop_lamp_o    <= rs_d;
         error_lamp_o       <= er_d;
         maintenance_lamp_o <= mt_d;
      end
   end

   // Register status flags
   // Space shortage aborts writes but leaves paired run standing
   always @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         paired_run_o       <= 1'b0;
         card_write_abort_o <= 1'b0;
      end
      else
      begin
         paired_run_o       <= paired;
         card_write_abort_o <= paired && card_space_low_i;
      end
   end

   // Per port link lamp next value, one generate entry per port
   // Flash test overrides traffic so every link lamp blinks together
   genvar gi;
   generate
      for (gi = 0; gi < NPORT; gi = gi + 1)
      begin : g_link
         reg [1:0] lk_d;

         // Priority: supply, flash test, connection, traffic
         always @*
         begin
            lk_d = `SLE_LAMP_OFF;
            if (!supply_ok_i)
               lk_d = `SLE_LAMP_OFF;
            else if (lamp_test_i)
               lk_d = fl_g;
            else if (!link_up_i[gi])
               lk_d = `SLE_LAMP_OFF;
            else if (link_act_i[gi])
               lk_d = fl_yg;
            else
               lk_d = `SLE_LAMP_GREEN;
         end
         assign link_d[2*gi+1:2*gi] = lk_d;
      end
   endgenerate

   // Register link lamps, one process for the whole vector
   always @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
         link_lamp_o <= {NPORT{`SLE_LAMP_OFF}};
      else
         link_lamp_o <= link_d;
   end

endmodule

// ---- shared/sle_map.vh ----
// Constants for the status lamp encoder
`ifndef SLE_MAP_VH
`define SLE_MAP_VH
// Lamp colour codes: bit 1 green, bit 0 yellow
`define SLE_LAMP_OFF     2'h0
`define SLE_LAMP_YELLOW  2'h1
`define SLE_LAMP_GREEN   2'h2
// Blink half period in ns and clock period in ns
`define SLE_BLINK_HALF_NS 250000000
`define SLE_CLK_PERIOD_NS 10
// Operating state codes on state_code_i
`define SLE_ST_STOP      3'h0
`define SLE_ST_STARTUP   3'h1
`define SLE_ST_WARM      3'h2
`define SLE_ST_RUN       3'h3
`define SLE_ST_RUN_SYNC  3'h4
`define SLE_ST_RUN_PAIR  3'h5
`define SLE_ST_SYNCUP    3'h6
// Pattern selector codes
`define SLE_PAT_DARK     4'h0
`define SLE_PAT_TEST     4'h1
`define SLE_PAT_DEFECT   4'h2
`define SLE_PAT_FW_OK    4'h3
`define SLE_PAT_STOP     4'h4
`define SLE_PAT_SYNCUP   4'h5
`define SLE_PAT_WARM     4'h6
`define SLE_PAT_INTERNAL 4'h7
`define SLE_PAT_DIAG_MT  4'h8
`define SLE_PAT_DIAG     4'h9
`define SLE_PAT_MAINT    4'hA
`define SLE_PAT_RUN      4'hB
`define SLE_PAT_CLEAN    4'hC
`endif

// ---- tb/sle_lamp_obs.sv ----
// Operator model: counts lit samples of each lamp over a window
`timescale 1ns/1ps
module sle_lamp_obs (
   // Clock and window clear
   input  wire        sys_clk_i,
   input  wire        clr_i,
   // Observed lamps
   input  wire [1:0]  rs_i,
   input  wire        er_i,
   input  wire        mt_i,
   input  wire [1:0]  lk_i,
   // Counts: run green, run yellow, error, maint, link green, link yellow
   output logic [29:0] cnt_o
);
   wire [5:0] lit_w = {rs_i[1], rs_i[0], er_i, mt_i, lk_i[1], lk_i[0]};
   // Steady lamp counts every sample, flashing one about half
   always @(posedge sys_clk_i)
      for (int i = 0; i < 6; i++)
         cnt_o[5*i +: 5] <= clr_i ? 5'h00 : cnt_o[5*i +: 5] + {4'h0, lit_w[i]};
endmodule

// ---- tb/sle_lamp_props.sv ----
// Checker for the status lamp encoder front and link lamps
`timescale 1ns/1ps
`include "sle_map.vh"
module sle_lamp_props #(
   parameter NPORT = 6
) (
   // Clock, reset and conditions
   input wire               sys_clk_i, reset_n_i, supply_ok_i, boot_i, lamp_test_i,
   input wire               defect_i, fw_fail_i, fw_ok_i, init_done_i, internal_act_i,
   input wire               partner_paired_i, diag_event_i, maint_demand_i, card_space_low_i,
   input wire [2:0]         state_code_i,
   input wire [NPORT-1:0]   link_up_i, link_act_i,
   // Lamps and status
   input wire [1:0]         run_stop_lamp_o,
   input wire               error_lamp_o, maintenance_lamp_o, paired_run_o, card_write_abort_o,
   input wire [2*NPORT-1:0] link_lamp_o
);
   logic [1:0] live_q;
   // No overriding condition present
   wire calm_w = live_q[1] & supply_ok_i & ~(boot_i | lamp_test_i | defect_i | fw_fail_i
                 | fw_ok_i | internal_act_i | init_done_i);
   wire pair_w = state_code_i == `SLE_ST_RUN_PAIR && partner_paired_i;
   // Skip the edges right after release, outputs may still be clear
   always @(posedge sys_clk_i)
      live_q <= reset_n_i ? {live_q[0], 1'b1} : 2'h0;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_pair_calm;
      calm_w && pair_w;
   endsequence
   property p_dark;
      live_q[1] && !supply_ok_i |=> run_stop_lamp_o == `SLE_LAMP_OFF && !error_lamp_o
         && !maintenance_lamp_o;
   endproperty
   property p_test;
      live_q[1] && supply_ok_i && boot_i |=> error_lamp_o == maintenance_lamp_o
         && run_stop_lamp_o == (error_lamp_o ? `SLE_LAMP_GREEN : `SLE_LAMP_YELLOW);
   endproperty
   property p_defect;
      live_q[1] && supply_ok_i && !boot_i && !lamp_test_i && defect_i
         |=> run_stop_lamp_o == `SLE_LAMP_YELLOW && error_lamp_o == maintenance_lamp_o;
   endproperty
   property p_clean;
      s_pair_calm ##0 (!diag_event_i && !maint_demand_i)
         |=> run_stop_lamp_o == `SLE_LAMP_GREEN && !error_lamp_o;
   endproperty
   property p_diag;
      s_pair_calm ##0 (diag_event_i && !maint_demand_i)
         |=> run_stop_lamp_o == `SLE_LAMP_GREEN && !maintenance_lamp_o;
   endproperty
   property p_maint;
      calm_w && state_code_i != `SLE_ST_WARM && state_code_i <= `SLE_ST_SYNCUP
         && (!pair_w || maint_demand_i) |=> maintenance_lamp_o;
   endproperty
   property p_warm;
      calm_w && state_code_i == `SLE_ST_WARM |=> !error_lamp_o && !maintenance_lamp_o
         && run_stop_lamp_o != `SLE_LAMP_GREEN;
   endproperty
   property p_abort;
      live_q[1] && pair_w && card_space_low_i |=> card_write_abort_o && paired_run_o;
   endproperty
   property p_link_up;
      live_q[1] && supply_ok_i && !boot_i && !lamp_test_i && link_up_i == '1
         && link_act_i == '0 |=> link_lamp_o == {NPORT{`SLE_LAMP_GREEN}};
   endproperty
   property p_link_off;
      live_q[1] && !boot_i && !lamp_test_i && link_up_i == '0 && link_act_i == '0
         |=> link_lamp_o == '0;
   endproperty
   a_dark: assert property (p_dark) else $error("front lamps lit without supply");
   a_test: assert property (p_test) else $error("lamp test pattern wrong");
   a_defect: assert property (p_defect) else $error("defect pattern wrong");
   a_clean: assert property (p_clean) else $error("paired run pattern wrong");
   a_diag: assert property (p_diag) else $error("diagnostic pattern wrong");
   a_maint: assert property (p_maint) else $error("maintenance lamp dark");
   a_warm: assert property (p_warm) else $error("warm restart pattern wrong");
   a_abort: assert property (p_abort) else $error("card abort or pairing lost");
   a_link_up: assert property (p_link_up) else $error("link lamps not green");
   a_link_off: assert property (p_link_off) else $error("link lamps not dark");
endmodule
bind sle_status_lamp_encoder sle_lamp_props #(.NPORT(NPORT)) sle_lamp_props_inst (
   .sys_clk_i, .reset_n_i, .supply_ok_i, .boot_i, .lamp_test_i, .defect_i, .fw_fail_i,
   .fw_ok_i, .init_done_i, .internal_act_i, .partner_paired_i, .diag_event_i,
   .maint_demand_i, .card_space_low_i, .state_code_i, .link_up_i, .link_act_i,
   .run_stop_lamp_o, .error_lamp_o, .maintenance_lamp_o, .paired_run_o,
   .card_write_abort_o, .link_lamp_o);

// ---- tb/tb_top.sv ----
// Testbench for the status lamp encoder
`timescale 1ns/1ps
`include "sle_map.vh"
module tb_top;
   localparam [14:0] SU = 15'h4000, BT = 15'h2000, TS = 15'h1000, DF = 15'h0800,
      FF = 15'h0400, FO = 15'h0200, IN = 15'h0100, IA = 15'h0080, PA = 15'h0040,
      DG = 15'h0020, MD = 15'h0010, FJ = 15'h0008, FC = 15'h0004, SO = 15'h0002;
   logic sys_clk_i, reset_n_i, supply_ok_i, boot_i, lamp_test_i, defect_i, fw_fail_i;
   logic fw_ok_i, init_done_i, internal_act_i, partner_paired_i, diag_event_i;
   logic maint_demand_i, force_job_i, fcycle_warn_i, safety_off_i, card_space_low_i;
   logic error_lamp_o, maintenance_lamp_o, paired_run_o, card_write_abort_o, obs_clr;
   logic [14:0] cond;
   logic [2:0]  state_code_i;
   logic [5:0]  link_up_i, link_act_i, lk_up, lk_act;
   logic [1:0]  run_stop_lamp_o;
   logic [11:0] link_lamp_o;
   logic [29:0] obs_cnt;
   integer      error_cnt = 0;
   integer      cmp_count = 0;
   assign {supply_ok_i, boot_i, lamp_test_i, defect_i, fw_fail_i, fw_ok_i, init_done_i,
           internal_act_i, partner_paired_i, diag_event_i, maint_demand_i, force_job_i,
           fcycle_warn_i, safety_off_i, card_space_low_i} = cond;
   // Short blink half period keeps windows small
   sle_status_lamp_encoder #(.BLINK_HALF(4), .BLINK_CW(3)) sle_status_lamp_encoder_inst (
      .sys_clk_i, .reset_n_i, .supply_ok_i, .boot_i, .lamp_test_i, .defect_i, .fw_fail_i,
      .fw_ok_i, .state_code_i, .init_done_i, .internal_act_i, .partner_paired_i,
      .diag_event_i, .maint_demand_i, .force_job_i, .fcycle_warn_i, .safety_off_i,
      .card_space_low_i, .link_up_i, .link_act_i, .run_stop_lamp_o, .error_lamp_o,
      .maintenance_lamp_o, .link_lamp_o, .paired_run_o, .card_write_abort_o);
   sle_lamp_obs sle_lamp_obs_inst (.sys_clk_i, .clr_i(obs_clr), .rs_i(run_stop_lamp_o),
      .er_i(error_lamp_o), .mt_i(maintenance_lamp_o), .lk_i(link_lamp_o[1:0]),
      .cnt_o(obs_cnt));
   // Clock
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // Compare tasks and verdict
   task automatic chk_cnt(input string nm, input [4:0] exp, input [4:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
      end
   endtask
   task automatic chk_bit(input string nm, input exp, input got);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic chk_vec(input string nm, input [11:0] exp, input [11:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task results;
      if (error_cnt == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Apply conditions, let output settle, watch a 16 cycle window (2 blink periods)
   // e: two bits per lamp, 0 dark, 1 flashing, 2 steady; f: paired, abort
   task automatic run_case(input [14:0] c, input [2:0] st, input [11:0] e, input [1:0] f);
      @(posedge sys_clk_i);
      cond <= c;
      state_code_i <= st;
      link_up_i <= lk_up;
      link_act_i <= lk_act;
      repeat (3) @(posedge sys_clk_i);
      obs_clr <= 1'b1;
      @(posedge sys_clk_i);
      obs_clr <= 1'b0;
      repeat (16) @(posedge sys_clk_i);
      #1;
      for (int i = 0; i < 6; i++)
         chk_cnt($sformatf("lamp%0d", i), {e[2*i +: 2], 3'h0}, obs_cnt[5*i +: 5]);
      chk_bit("paired_run_o", f[1], paired_run_o);
      chk_bit("card_write_abort_o", f[0], card_write_abort_o);
   endtask
   // Main sequence
   initial
   begin
      cond = 15'h0000;
      state_code_i = 3'h0;
      {link_up_i, link_act_i, lk_act} = 18'h00000;
      lk_up = 6'h3F;
      obs_clr = 1'b0;
      reset_n_i = 1'b0;
      repeat (16) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      run_case(BT, 3'h5, 12'h000, 2'h0);
      run_case(SU | BT, 3'h0, 12'h558, 2'h0);
      run_case(SU | TS | DF | PA, 3'h5, 12'h554, 2'h2);
      run_case(SU | DF | PA, 3'h5, 12'h258, 2'h2);
      run_case(SU | FF, 3'h0, 12'h258, 2'h0);
      run_case(SU | FO, 3'h3, 12'h218, 2'h0);
      run_case(SU, 3'h0, 12'h228, 2'h0);
      run_case(SU | IN, 3'h3, 12'h228, 2'h0);
      run_case(SU | IA, 3'h0, 12'h128, 2'h0);
      run_case(SU | IA | PA, 3'h5, 12'h808, 2'h2);
      run_case(SU, 3'h6, 12'h528, 2'h0);
      run_case(SU, 3'h2, 12'h108, 2'h0);
      run_case(SU | MD, 3'h3, 12'h828, 2'h0);
      run_case(SU, 3'h4, 12'h828, 2'h0);
      run_case(SU | FJ | PA, 3'h5, 12'h828, 2'h2);
      run_case(SU | FC | PA, 3'h5, 12'h828, 2'h2);
      run_case(SU | SO | PA, 3'h5, 12'h828, 2'h2);
      run_case(SU | PA, 3'h5, 12'h808, 2'h2);
      run_case(SU, 3'h5, 12'h828, 2'h0);
      run_case(SU | DG | PA, 3'h5, 12'h848, 2'h2);
      run_case(SU | DG | MD | PA, 3'h5, 12'h868, 2'h2);
      run_case(SU | MD | PA, 3'h5, 12'h828, 2'h2);
      run_case(SU | PA | 15'h0001, 3'h5, 12'h808, 2'h3);
      lk_act = 6'h3F;
      run_case(SU | PA, 3'h5, 12'h805, 2'h2);
      {lk_up, lk_act} = 12'hF80;
      run_case(SU | PA, 3'h5, 12'h800, 2'h2);
      chk_vec("link_lamp_o", 12'hAA8, link_lamp_o);
      lk_up = 6'h00;
      run_case(SU | PA, 3'h5, 12'h800, 2'h2);
      chk_vec("link_lamp_o", 12'h000, link_lamp_o);
      results();
   end
   // Watchdog far beyond the expected run length
   initial
   begin
      repeat (20000) @(posedge sys_clk_i);
      error_cnt++;
      results();
   end
endmodule
